// ### design/pfc_ctrl.sv
// host controller that issues flash command sequences and polls status
`timescale 1ns/1ps
`include "pfc_map.svh"
module pfc_ctrl #(
  parameter int AW           = 19,
  parameter int ERASE_TO_CYC = `PFC_ERASE_MAX_CYC
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               cmd_valid,
  input  wire pfc_pkg::pfc_op_t   cmd_op,
  input  wire logic [AW-1:0]      cmd_addr,
  input  wire logic [15:0]        cmd_data,
  output logic                    cmd_ready,
  output logic                    rsp_valid,
  output logic [15:0]             rsp_data,
  output logic                    rsp_timeout,
  output pfc_pkg::pfc_mode_t      dev_mode,
  output logic [AW-1:0]           flash_addr,
  input  wire logic [15:0]        flash_dq_i,
  output logic [15:0]             flash_dq_o,
  output logic                    flash_dq_oe,
  output logic                    flash_ce_n,
  output logic                    flash_oe_n,
  output logic                    flash_we_n
);
  localparam int PROG_CYC   = `PFC_PROG_MAX_NS / `PFC_MCLK_NS;
  localparam int SETTLE_CYC = (`PFC_SETTLE_NS + `PFC_MCLK_NS - 1) / `PFC_MCLK_NS;
  localparam int TW         = 24;
  typedef enum {
    ST_IDLE, ST_WR_ISSUE, ST_WR_WAIT, ST_POLL_ISSUE, ST_POLL_WAIT,
    ST_SETTLE, ST_FINAL_ISSUE, ST_FINAL_WAIT, ST_ABORT, ST_ABORT_WAIT, ST_REPLY
  } pfc_state_t;
  // ****************************************************************
  // request and sequence state
  // ****************************************************************
  pfc_state_t         state_q;
  pfc_pkg::pfc_op_t   op_q;
  logic [AW-1:0]      addr_q;
  logic [15:0]        data_q;
  logic [2:0]         step_q;
  logic [TW-1:0]      tmr_q;
  logic               tog_q;
  logic               have_tog_q;
  logic               bus_start_q;
  logic               bus_wr_q;
  logic [AW-1:0]      bus_addr_q;
  logic [15:0]        bus_wdata_q;
  logic               bus_done;
  logic [15:0]        bus_rdata;
  // ****************************************************************
  // command sequence decode
  // ****************************************************************
  wire is_prog   = (op_q == pfc_pkg::PFC_OP_PROGRAM);
  wire is_chip   = (op_q == pfc_pkg::PFC_OP_CHIP_ERASE);
  wire is_short  = (op_q == pfc_pkg::PFC_OP_EXIT_SHORT);
  wire is_erase  = (op_q == pfc_pkg::PFC_OP_SECTOR_ERASE) ||
                   (op_q == pfc_pkg::PFC_OP_BLOCK_ERASE) || is_chip;
  wire is_busy_op = is_prog || is_erase;
  wire [2:0] seq_len = is_short ? 3'h1 : is_prog ? 3'h4 : is_erase ? 3'h6 : 3'h3;
  wire last_step = (step_q == seq_len - 3'h1);
  wire unlock2   = (step_q == 3'h1) || (step_q == 3'h4);
  wire prog_data_step = is_prog && (step_q == 3'h3);
  wire target_step = prog_data_step || is_short || ((step_q == 3'h5) && !is_chip);
  wire [7:0] third_byte =
      is_prog  ? `PFC_CMD_PROGRAM :
      is_erase ? `PFC_CMD_ERASE_SETUP :
      (op_q == pfc_pkg::PFC_OP_ID_ENTRY) ? `PFC_CMD_ID_ENTRY :
      (op_q == pfc_pkg::PFC_OP_QUERY_ENTRY) ? `PFC_CMD_QUERY_ENTRY :
      `PFC_CMD_EXIT;
  wire [7:0] last_byte =
      (op_q == pfc_pkg::PFC_OP_SECTOR_ERASE) ? `PFC_CMD_SECTOR_ERASE :
      (op_q == pfc_pkg::PFC_OP_BLOCK_ERASE) ? `PFC_CMD_BLOCK_ERASE :
      `PFC_CMD_CHIP_ERASE;
  wire [7:0] seq_byte =
      is_short ? `PFC_CMD_EXIT :
      unlock2 ? `PFC_UNLOCK2_DATA :
      (step_q == 3'h2) ? third_byte :
      (step_q == 3'h5) ? last_byte :
      `PFC_UNLOCK1_DATA;
  // upper data lines are driven low in command cycles, upper address bits in cycles to the unlock addresses
  wire [15:0] seq_wdata = prog_data_step ? data_q : {`PFC_UPPER_ZERO, seq_byte};
  wire [14:0] unlock_addr = unlock2 ? `PFC_UNLOCK2_ADDR : `PFC_UNLOCK1_ADDR;
  wire [AW-1:0] seq_addr = target_step ? addr_q :
                           {{(AW - `PFC_CMD_ADDR_W){1'b0}}, unlock_addr};
  // ****************************************************************
  // status evaluation
  // ****************************************************************
  // program: polling bit reads inverted until done; erase: reads zero until done
  wire poll_ok = is_prog ?
                 (bus_rdata[`PFC_POLL_BIT] == data_q[`PFC_POLL_BIT]) :
                 bus_rdata[`PFC_POLL_BIT];
  // two reads with equal toggle bit mean the internal operation has ended
  wire tog_still = have_tog_q && (bus_rdata[`PFC_TOGGLE_BIT] == tog_q);
  wire [TW-1:0] tmo_lim = is_prog ? TW'(PROG_CYC) : TW'(ERASE_TO_CYC);
  wire timed_out = (tmr_q >= tmo_lim);
  wire settle_end = (tmr_q >= TW'(SETTLE_CYC - 1));
  // ****************************************************************
  // control sequencer
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      op_q        <= pfc_pkg::PFC_OP_READ;
      addr_q      <= '0;
      data_q      <= 16'h0000;
      step_q      <= 3'h0;
      tmr_q       <= '0;
      tog_q       <= 1'b0;
      have_tog_q  <= 1'b0;
      bus_start_q <= 1'b0;
      bus_wr_q    <= 1'b0;
      bus_addr_q  <= '0;
      bus_wdata_q <= 16'h0000;
      cmd_ready   <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_data    <= 16'h0000;
      rsp_timeout <= 1'b0;
      dev_mode    <= pfc_pkg::PFC_MODE_ARRAY;
    end else begin
      bus_start_q <= 1'b0;
      rsp_valid   <= 1'b0;
      tmr_q       <= tmr_q + TW'(1);
      case (state_q)
        ST_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready   <= 1'b0;
            op_q        <= cmd_op;
            addr_q      <= cmd_addr;
            data_q      <= cmd_data;
            step_q      <= 3'h0;
            rsp_timeout <= 1'b0;
            rsp_data    <= 16'h0000;
            state_q     <= (cmd_op == pfc_pkg::PFC_OP_READ) ? ST_FINAL_ISSUE : ST_WR_ISSUE;
          end
        end
        ST_WR_ISSUE: begin
          bus_start_q <= 1'b1;
          bus_wr_q    <= 1'b1;
          bus_addr_q  <= seq_addr;
          bus_wdata_q <= seq_wdata;
          state_q     <= ST_WR_WAIT;
        end
        ST_WR_WAIT: if (bus_done) begin
          if (!last_step) begin
            step_q  <= step_q + 3'h1;
            state_q <= ST_WR_ISSUE;
          end else if (is_busy_op) begin
            // status is read only after the final write strobe has risen
            tmr_q      <= '0;
            have_tog_q <= 1'b0;
            state_q    <= ST_POLL_ISSUE;
          end else begin
            if (op_q == pfc_pkg::PFC_OP_ID_ENTRY) dev_mode <= pfc_pkg::PFC_MODE_ID;
            else if (op_q == pfc_pkg::PFC_OP_QUERY_ENTRY)
              dev_mode <= pfc_pkg::PFC_MODE_QUERY;
            else dev_mode <= pfc_pkg::PFC_MODE_ARRAY;
            state_q <= ST_REPLY;
          end
        end
        ST_POLL_ISSUE: begin
          bus_start_q <= 1'b1;
          bus_wr_q    <= 1'b0;
          bus_addr_q  <= addr_q;
          state_q     <= ST_POLL_WAIT;
        end
        // no command is written until status shows the operation ended or the poll limit is reached
        ST_POLL_WAIT: if (bus_done) begin
          if (poll_ok && tog_still) begin
            tmr_q   <= '0;
            state_q <= ST_SETTLE;
          end else if (timed_out) begin
            state_q <= ST_ABORT;
          end else begin
            tog_q      <= bus_rdata[`PFC_TOGGLE_BIT];
            have_tog_q <= 1'b1;
            state_q    <= ST_POLL_ISSUE;
          end
        end
        // other data lines may lag the polling bit, so wait before the last read
        ST_SETTLE: if (settle_end) state_q <= ST_FINAL_ISSUE;
        ST_FINAL_ISSUE: begin
          bus_start_q <= 1'b1;
          bus_wr_q    <= 1'b0;
          bus_addr_q  <= addr_q;
          state_q     <= ST_FINAL_WAIT;
        end
        ST_FINAL_WAIT: if (bus_done) begin
          rsp_data <= bus_rdata;
          state_q  <= ST_REPLY;
        end
        // after a timeout, a single reset write returns the part to read mode
        ST_ABORT: begin
          rsp_timeout <= 1'b1;
          bus_start_q <= 1'b1;
          bus_wr_q    <= 1'b1;
          bus_addr_q  <= addr_q;
          bus_wdata_q <= {`PFC_UPPER_ZERO, `PFC_CMD_EXIT};
          state_q     <= ST_ABORT_WAIT;
        end
        ST_ABORT_WAIT: if (bus_done) begin
          dev_mode <= pfc_pkg::PFC_MODE_ARRAY;
          state_q  <= ST_REPLY;
        end
        ST_REPLY: begin
          rsp_valid <= 1'b1;
          state_q   <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // ****************************************************************
  // pin cycle engine
  // ****************************************************************
  pfc_bus_cycle #(
    .AW (AW)
  ) u_cycle (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .start     (bus_start_q),
    .wr        (bus_wr_q),
    .addr      (bus_addr_q),
    .wdata     (bus_wdata_q),
    .done      (bus_done),
    .rdata     (bus_rdata),
    .pin_addr  (flash_addr),
    .pin_dq_i  (flash_dq_i),
    .pin_dq_o  (flash_dq_o),
    .pin_dq_oe (flash_dq_oe),
    .pin_ce_n  (flash_ce_n),
    .pin_oe_n  (flash_oe_n),
    .pin_we_n  (flash_we_n)
  );
endmodule : pfc_ctrl

// ### design/pfc_map.svh
// pin-level constants of the parallel flash command controller
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH
`define PFC_MCLK_NS          25
`define PFC_GLITCH_NS        5
`define PFC_READ_CYCLE_NS    70
`define PFC_SETTLE_NS        1000
`define PFC_PROG_MAX_NS      20000
`define PFC_ERASE_MAX_CYC    5120000
`define PFC_UNLOCK1_ADDR     15'h5555
`define PFC_UNLOCK2_ADDR     15'h2AAA
`define PFC_UNLOCK1_DATA     8'hAA
`define PFC_UNLOCK2_DATA     8'h55
`define PFC_CMD_PROGRAM      8'hA0
`define PFC_CMD_ERASE_SETUP  8'h80
`define PFC_CMD_SECTOR_ERASE 8'h30
`define PFC_CMD_BLOCK_ERASE  8'h50
`define PFC_CMD_CHIP_ERASE   8'h10
`define PFC_CMD_ID_ENTRY     8'h90
`define PFC_CMD_QUERY_ENTRY  8'h98
`define PFC_CMD_EXIT         8'hF0
`define PFC_UPPER_ZERO       8'h00
`define PFC_CMD_ADDR_W       15
`define PFC_POLL_BIT         7
`define PFC_TOGGLE_BIT       6
`define PFC_SYNC_CYC         3
`endif

// ### design/pfc_pkg.sv
// types shared by the parallel flash command controller
package pfc_pkg;
  typedef enum logic [3:0] {
    PFC_OP_READ,
    PFC_OP_PROGRAM,
    PFC_OP_SECTOR_ERASE,
    PFC_OP_BLOCK_ERASE,
    PFC_OP_CHIP_ERASE,
    PFC_OP_ID_ENTRY,
    PFC_OP_QUERY_ENTRY,
    PFC_OP_EXIT_SHORT,
    PFC_OP_EXIT_LONG
  } pfc_op_t;
  typedef enum logic [1:0] {
    PFC_MODE_ARRAY,
    PFC_MODE_ID,
    PFC_MODE_QUERY
  } pfc_mode_t;
  typedef enum logic [2:0] {
    PFC_PH_IDLE,
    PFC_PH_SETUP,
    PFC_PH_STROBE,
    PFC_PH_HOLD,
    PFC_PH_GAP
  } pfc_phase_t;
endpackage : pfc_pkg

// ### design/pfc_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
`include "pfc_map.svh"
module pfc_bus_cycle #(
  parameter int AW = 19
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          start,
  input  wire logic          wr,
  input  wire logic [AW-1:0] addr,
  input  wire logic [15:0]   wdata,
  output logic               done,
  output logic [15:0]        rdata,
  output logic [AW-1:0]      pin_addr,
  input  wire logic [15:0]   pin_dq_i,
  output logic [15:0]        pin_dq_o,
  output logic               pin_dq_oe,
  output logic               pin_ce_n,
  output logic               pin_oe_n,
  output logic               pin_we_n
);
  // strobe held strictly longer than the glitch filter so the write is counted
  localparam int WE_CYC  = `PFC_GLITCH_NS / `PFC_MCLK_NS + 2;
  localparam int RD_CYC  = (`PFC_READ_CYCLE_NS + `PFC_MCLK_NS - 1) / `PFC_MCLK_NS;
  localparam int GAP_CYC = (`PFC_READ_CYCLE_NS + `PFC_MCLK_NS - 1) / `PFC_MCLK_NS;
  // ****************************************************************
  // input synchroniser
  // ****************************************************************
  logic [15:0] sync1_q, sync2_q, sync3_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
      sync3_q <= 16'h0000;
    end else begin
      sync1_q <= pin_dq_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  // ****************************************************************
  // cycle sequencer
  // ****************************************************************
  pfc_pkg::pfc_phase_t phase_q;
  logic [3:0]          cnt_q;
  logic                wr_q;
  wire settled   = (sync2_q == sync3_q);
  wire wr_end    = (cnt_q >= 4'(WE_CYC - 1));
  wire rd_end    = (cnt_q >= 4'(RD_CYC + `PFC_SYNC_CYC)) && settled;
  wire strobe_end = wr_q ? wr_end : rd_end;
  wire gap_end   = (cnt_q >= 4'(GAP_CYC - 1));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q   <= pfc_pkg::PFC_PH_IDLE;
      cnt_q     <= 4'h0;
      wr_q      <= 1'b0;
      done      <= 1'b0;
      rdata     <= 16'h0000;
      pin_addr  <= '0;
      pin_dq_o  <= 16'h0000;
      pin_dq_oe <= 1'b0;
      pin_ce_n  <= 1'b1;
      pin_oe_n  <= 1'b1;
      pin_we_n  <= 1'b1;
    end else begin
      done <= 1'b0;
      cnt_q <= cnt_q + 4'h1;
      case (phase_q)
        pfc_pkg::PFC_PH_IDLE: if (start) begin
          // address and data settle a cycle before the strobes fall
          wr_q      <= wr;
          pin_addr  <= addr;
          pin_dq_o  <= wdata;
          pin_dq_oe <= wr;
          phase_q   <= pfc_pkg::PFC_PH_SETUP;
        end
        pfc_pkg::PFC_PH_SETUP: begin
          pin_ce_n <= 1'b0;
          pin_we_n <= !wr_q;
          pin_oe_n <= wr_q;
          cnt_q    <= 4'h0;
          phase_q  <= pfc_pkg::PFC_PH_STROBE;
        end
        pfc_pkg::PFC_PH_STROBE: if (strobe_end) begin
          rdata    <= sync3_q;
          pin_ce_n <= 1'b1;
          pin_we_n <= 1'b1;
          pin_oe_n <= 1'b1;
          phase_q  <= pfc_pkg::PFC_PH_HOLD;
        end
        pfc_pkg::PFC_PH_HOLD: begin
          // data held past the rising strobe edge
          pin_dq_oe <= 1'b0;
          cnt_q     <= 4'h0;
          phase_q   <= pfc_pkg::PFC_PH_GAP;
        end
        pfc_pkg::PFC_PH_GAP: if (gap_end) begin
          // recovery of one read cycle time lets an aborted sequence settle
          done    <= 1'b1;
          phase_q <= pfc_pkg::PFC_PH_IDLE;
        end
        default: phase_q <= pfc_pkg::PFC_PH_IDLE;
      endcase
    end
  end
endmodule : pfc_bus_cycle

// ### testbench/pfc_ctrl_properties.sv
// concurrent checks on the controller's flash pins and user handshake
`timescale 1ns/1ps
module pfc_ctrl_properties #(
  parameter int AW = 19
) (
  input wire logic          mclk,
  input wire logic          rst_n,
  input wire logic          cmd_valid,
  input wire logic          cmd_ready,
  input wire logic          rsp_valid,
  input wire logic          rsp_timeout,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [15:0]   flash_dq_o,
  input wire logic          flash_dq_oe,
  input wire logic          flash_ce_n,
  input wire logic          flash_oe_n,
  input wire logic          flash_we_n
);
  // ******************************
  // pin and handshake properties
  // ******************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_write_inhibit: assert property (!flash_we_n |-> flash_oe_n && !flash_ce_n)
    else $error("strobe with gate low or chip idle");
  chk_strobe_width: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
    else $error("strobe not two cycles");
  chk_addr_setup: assert property ($fell(flash_we_n) |-> $stable(flash_addr) && flash_dq_oe)
    else $error("address moved at strobe fall");
  chk_data_hold: assert property ($rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_o))
    else $error("data not held to strobe rise");
  chk_read_float: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("host drives data in read");
  chk_read_width: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*6])
    else $error("read gate too short");
  chk_cycle_gap: assert property ($rose(flash_ce_n) |=> flash_ce_n [*3])
    else $error("bus gap too short");
  chk_idle_quiet: assert property (cmd_ready |-> flash_ce_n && !flash_dq_oe)
    else $error("pin activity while idle");
  chk_ready_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready high after accept");
  chk_ready_back: assert property (rsp_valid |=> cmd_ready && !rsp_valid)
    else $error("ready not back after response");
  cov_write: cover property ($fell(flash_we_n));
  cov_read: cover property ($fell(flash_oe_n));
  cov_timeout: cover property (rsp_valid && rsp_timeout);
endmodule : pfc_ctrl_properties

bind pfc_ctrl pfc_ctrl_properties #(.AW(AW)) i_props (
  .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .rsp_timeout(rsp_timeout), .flash_addr(flash_addr),
  .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n)
);

// ### testbench/pfc_flash_model.sv
// behavioural x16 parallel flash facing the controller's pins
`timescale 1ns/1ps
module pfc_flash_model #(
  parameter int          PROG_NS = 8000,
  parameter logic [15:0] MAKER   = 16'h1C5A,
  parameter logic [15:0] PART    = 16'h7E31
) (
  input  wire logic [18:0] addr,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [31:0] erase_ns,
  output logic             busy,
  output int               writes,
  output int               bad_seq
);
  // ******************************
  // command decoder and status
  // ******************************
  logic [15:0] mem [256];
  logic [15:0] pdata, base, rlast;
  logic [18:0] lat_a;
  logic [2:0]  stage;
  logic        erasing, settle, tog;
  int          dur;
  time         t_fall;
  event        go;
  pfc_pkg::pfc_mode_t mode;
  wire wr = !ce_n && !we_n && oe_n;
  wire rd = !ce_n && !oe_n;
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    mode = pfc_pkg::PFC_MODE_ARRAY;
    {stage, erasing, settle, tog, busy, rlast, pdata} = '0;
    writes = 0;
    bad_seq = 0;
  end
  task automatic begin_op(input int ns, input logic er);
    dur = ns;
    erasing = er;
    settle = 1'b0;
    busy = 1'b1;
    -> go;
  endtask : begin_op
  task automatic commit(input logic [18:0] a, input logic [15:0] d);
    logic [7:0] v;
    logic ok;
    v = d[7:0];
    ok = 1'b1;
    writes++;
    if (busy) return;
    if (stage == 3'h0 && v == 8'hF0) mode = pfc_pkg::PFC_MODE_ARRAY;
    else begin
      case (stage)
        3'h0, 3'h4: ok = a[14:0] == 15'h5555 && v == 8'hAA;
        3'h1, 3'h5: ok = a[14:0] == 15'h2AAA && v == 8'h55;
        3'h2: begin
          ok = a[14:0] == 15'h5555 && v inside {8'hA0, 8'h80, 8'h90, 8'h98, 8'hF0};
          if (ok && v == 8'h90) mode = pfc_pkg::PFC_MODE_ID;
          if (ok && v == 8'h98) mode = pfc_pkg::PFC_MODE_QUERY;
          if (ok && v == 8'hF0) mode = pfc_pkg::PFC_MODE_ARRAY;
        end
        3'h3: begin
          mem[a[7:0]] = d;
          pdata = d;
          begin_op(PROG_NS, 1'b0);
        end
        default: begin
          ok = v inside {8'h30, 8'h50} || (a[14:0] == 15'h5555 && v == 8'h10);
          if (ok) foreach (mem[i]) mem[i] = 16'hFFFF;
          if (ok) begin_op(erase_ns, 1'b1);
        end
      endcase
      if (!ok || stage == 3'h3 || stage == 3'h6) stage = 3'h0;
      else if (stage != 3'h2) stage = stage + 3'h1;
      else stage = v == 8'hA0 ? 3'h3 : v == 8'h80 ? 3'h4 : 3'h0;
      bad_seq += int'(!ok);
    end
  endtask : commit
  always @(posedge wr) begin
    lat_a = addr;
    t_fall = $time;
  end
  always @(negedge wr) if ($time - t_fall >= 5) commit(lat_a, dq_in);
  always @(go) begin
    #(dur);
    busy = 1'b0;
    settle = 1'b1;
    // the settle window runs on its own so that a quick next command is not missed
    fork
      #1000 settle = 1'b0;
    join_none
  end
  always @(posedge rd) if (busy) tog = !tog;
  assign base = mode == pfc_pkg::PFC_MODE_ID ? (addr[14:1] != 14'h0 ? 16'h0 :
                addr[0] ? PART : MAKER) : mode == pfc_pkg::PFC_MODE_QUERY ?
                (addr[7:0] == 8'h10 ? 16'h0051 : 16'h0) : mem[addr[7:0]];
  wire [15:0] stat = {8'h0, erasing ? 1'b0 : ~pdata[7], tog, 6'h0};
  wire [15:0] rval = busy ? stat : settle ? base ^ 16'hFF7F : base;
  always @* if (rd) rlast = rval;
  // a released bus shows no stale word
  assign dq_out = rd ? rval : ~rlast;
endmodule : pfc_flash_model

// ### testbench/pfc_ctrl_bench.sv
// self-checking bench: flash command controller against a flash model
`timescale 1ns/1ps
module pfc_ctrl_bench;
  typedef struct packed {
    pfc_pkg::pfc_op_t   op;
    logic [18:0]        a;
    logic [15:0]        d;
    logic [15:0]        rsp;
    pfc_pkg::pfc_mode_t m;
    logic [3:0]         nw;
  } pfc_row_t;
  localparam logic [15:0] MAKER_ID = 16'h1C5A; // arbitrary value
  localparam logic [15:0] PART_ID  = 16'h7E31; // arbitrary value
  localparam pfc_pkg::pfc_mode_t MA = pfc_pkg::PFC_MODE_ARRAY;
  localparam pfc_pkg::pfc_mode_t MI = pfc_pkg::PFC_MODE_ID;
  localparam pfc_pkg::pfc_mode_t MQ = pfc_pkg::PFC_MODE_QUERY;
  logic mclk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_timeout, busy;
  logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
  pfc_pkg::pfc_op_t   cmd_op;
  pfc_pkg::pfc_mode_t dev_mode;
  logic [18:0] cmd_addr, flash_addr;
  logic [15:0] cmd_data, rsp_data, flash_dq_o, dq_dev;
  logic [31:0] erase_ns;
  int          writes, bad_seq, fails, samples_checked, base;
  wire  [15:0] flash_dq_i = flash_dq_oe ? flash_dq_o : dq_dev;
  pfc_row_t rows [14] = '{
    '{pfc_pkg::PFC_OP_READ, 19'h10, 16'h0, 16'hFFFF, MA, 4'h0},
    '{pfc_pkg::PFC_OP_PROGRAM, 19'h10, 16'h1234, 16'h1234, MA, 4'h4},
    '{pfc_pkg::PFC_OP_PROGRAM, 19'h70020, 16'h00A5, 16'h00A5, MA, 4'h4},
    '{pfc_pkg::PFC_OP_ID_ENTRY, 19'h0, 16'h0, 16'h0, MI, 4'h3},
    '{pfc_pkg::PFC_OP_READ, 19'h0, 16'h0, MAKER_ID, MI, 4'h0},
    '{pfc_pkg::PFC_OP_READ, 19'h1, 16'h0, PART_ID, MI, 4'h0},
    '{pfc_pkg::PFC_OP_EXIT_SHORT, 19'h7, 16'h0, 16'h0, MA, 4'h1},
    '{pfc_pkg::PFC_OP_QUERY_ENTRY, 19'h0, 16'h0, 16'h0, MQ, 4'h3},
    '{pfc_pkg::PFC_OP_READ, 19'h10, 16'h0, 16'h0051, MQ, 4'h0},
    '{pfc_pkg::PFC_OP_EXIT_LONG, 19'h0, 16'h0, 16'h0, MA, 4'h3},
    '{pfc_pkg::PFC_OP_SECTOR_ERASE, 19'h10, 16'h0, 16'hFFFF, MA, 4'h6},
    '{pfc_pkg::PFC_OP_PROGRAM, 19'h20, 16'h8001, 16'h8001, MA, 4'h4},
    '{pfc_pkg::PFC_OP_BLOCK_ERASE, 19'h20, 16'h0, 16'hFFFF, MA, 4'h6},
    '{pfc_pkg::PFC_OP_CHIP_ERASE, 19'h10, 16'h0, 16'hFFFF, MA, 4'h6}
  };
  pfc_ctrl #(.AW(19), .ERASE_TO_CYC(2000)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_timeout(rsp_timeout),
    .dev_mode(dev_mode), .flash_addr(flash_addr), .flash_dq_i(flash_dq_i),
    .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n)
  );
  pfc_flash_model #(.MAKER(MAKER_ID), .PART(PART_ID)) i_flash (
    .addr(flash_addr), .dq_in(flash_dq_i), .dq_out(dq_dev), .ce_n(flash_ce_n),
    .oe_n(flash_oe_n), .we_n(flash_we_n), .erase_ns(erase_ns), .busy(busy),
    .writes(writes), .bad_seq(bad_seq)
  );
  // ******************************
  // tasks
  // ******************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic run(input pfc_pkg::pfc_op_t op, input logic [18:0] a, input logic [15:0] d);
    repeat (40) if (cmd_ready !== 1'b1) @(negedge mclk);
    check("cmd_ready", 32'h1, cmd_ready);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    repeat (12000) if (rsp_valid !== 1'b1) @(negedge mclk);
    check("rsp_valid", 32'h1, rsp_valid);
  endtask : run
  task automatic tally_and_finish();
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // ******************************
  // clock, watchdog and sequence
  // ******************************
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = !mclk;
  end
  initial begin
    #1_500_000;
    fails++;
    tally_and_finish();
  end
  initial begin
    {rst_n, cmd_valid, cmd_addr, cmd_data} = '0;
    cmd_op = pfc_pkg::PFC_OP_READ;
    erase_ns = 32'h2710;
    fails = 0;
    samples_checked = 0;
    repeat (16) @(negedge mclk);
    check("strobes_in_reset", 32'h7, {flash_ce_n, flash_oe_n, flash_we_n});
    check("ready_in_reset", 32'h0, cmd_ready);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      base = writes;
      run(rows[i].op, rows[i].a, rows[i].d);
      check("rsp_data", rows[i].rsp, rsp_data);
      check("dev_mode", rows[i].m, dev_mode);
      check("writes", rows[i].nw, writes - base);
      check("rsp_timeout", 32'h0, rsp_timeout);
    end
    // an erase that outlives the poll limit; the recovery write lands while busy
    erase_ns = 32'h30D40;
    base = writes;
    run(pfc_pkg::PFC_OP_SECTOR_ERASE, 19'h10, 16'h0);
    check("rsp_timeout", 32'h1, rsp_timeout);
    check("dev_mode", MA, dev_mode);
    check("writes", 32'h7, writes - base);
    check("still_busy", 32'h1, busy);
    erase_ns = 32'h2710;
    repeat (9000) if (busy) @(negedge mclk);
    check("busy_end", 32'h0, busy);
    run(pfc_pkg::PFC_OP_PROGRAM, 19'h30, 16'h0F0F);
    check("rsp_data", 32'h0F0F, rsp_data);
    check("bad_seq", 32'h0, bad_seq);
    // reset in the middle of a read must idle the pins and clear the reply
    repeat (2) @(negedge mclk);
    cmd_op = pfc_pkg::PFC_OP_READ;
    cmd_addr = 19'h30;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    repeat (5) @(negedge mclk);
    rst_n = 1'b0;
    @(negedge mclk);
    check("strobes_mid_reset", 32'h7, {flash_ce_n, flash_oe_n, flash_we_n});
    check("rsp_data_reset", 32'h0, rsp_data);
    check("ready_mid_reset", 32'h0, cmd_ready);
    rst_n = 1'b1;
    run(pfc_pkg::PFC_OP_READ, 19'h30, 16'h0);
    check("rsp_data", 32'h0F0F, rsp_data);
    tally_and_finish();
  end
endmodule : pfc_ctrl_bench
